// ---- design/acr_top.sv ----
// Clock, output rate and delay loop configuration with serial register access
`timescale 1ns/1ns
module acr_top #(
  parameter int CAL_STEP_CYC = acr_pkg::CAL_STEP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_n_o,
  input wire logic adc_valid_i,
  input wire logic [11:0] adc_data_i,
  input wire logic phase_delay_on_i,
  input wire logic calib_request_i,
  output logic out_valid_o,
  output logic [11:0] out_data_o,
  output logic word_clock_pin_o,
  output logic output_clock_pins_p_o,
  output logic output_clock_pins_n_o,
  output logic [2:0] out_clock_phase_o,
  output logic duty_correct_on_o,
  output logic delay_loop_on_o,
  output logic delay_loop_reset_o,
  output logic clock_buffer_on_o,
  output logic timing_source_synth_o,
  output logic [9:0] synth_ref_ratio_o,
  output logic [3:0] synth_out_ratio_o,
  output logic calib_busy_o,
  output logic calib_start_o
);
  logic [7:0] reg_q [acr_pkg::NREG];
  logic [acr_pkg::NREG-1:0] hit;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] cnt_q;
  logic [15:0] shift_q;
  logic [15:0] hdr_q;
  logic wr_stb_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_shift_q;
  logic [7:0] rd_data;
  logic rd_phase;
  logic out_edge;
  logic ld_q;

  // Serial register port
  assign sclk_rise = spi_sclk_i && !sclk_q;
  assign sclk_fall = !spi_sclk_i && sclk_q;
  assign rd_phase = hdr_q[acr_pkg::POS_RD] && (cnt_q > acr_pkg::HDR_LAST);
  assign out_edge = reg_q[acr_pkg::IDX_SERIAL][acr_pkg::POS_EDGE] ? sclk_fall : sclk_rise;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= spi_sclk_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || spi_cs_n_i) begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      hdr_q <= 16'h0000;
      wr_stb_q <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (sclk_rise) begin
        shift_q <= {shift_q[14:0], spi_sdi_i};
        if (cnt_q != 5'h1F) begin
          cnt_q <= 5'(cnt_q + 5'h01);
        end
        if (cnt_q == acr_pkg::HDR_LAST) begin
          hdr_q <= {shift_q[14:0], spi_sdi_i};
        end
        if (cnt_q == acr_pkg::FRAME_LAST && !hdr_q[acr_pkg::POS_RD]) begin
          wr_stb_q <= 1'b1;
          wr_data_q <= {shift_q[6:0], spi_sdi_i};
        end
      end
    end
  end
  always_comb begin
    rd_data = 8'h00;
    for (int k = 0; k < acr_pkg::NREG; k++) begin
      if (hit[k]) begin
        rd_data = reg_q[k] & acr_pkg::REG_MASK[k];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || spi_cs_n_i) begin
      ld_q <= 1'b0;
      rd_shift_q <= 8'h00;
      spi_sdo_o <= 1'b0;
      spi_sdo_oe_n_o <= 1'b1;
    end else begin
      spi_sdo_oe_n_o <= !rd_phase;
      ld_q <= sclk_rise && cnt_q == acr_pkg::HDR_LAST && shift_q[acr_pkg::POS_RD - 1];
      if (ld_q && reg_q[acr_pkg::IDX_SERIAL][acr_pkg::POS_EDGE]) begin
        rd_shift_q <= rd_data;
      end else if (ld_q || (rd_phase && out_edge)) begin
        spi_sdo_o <= ld_q ? rd_data[7] : rd_shift_q[7];
        rd_shift_q <= ld_q ? {rd_data[6:0], 1'b0} : {rd_shift_q[6:0], 1'b0};
      end
    end
  end

  // Register file, unmapped addresses read zero and ignore writes
  for (genvar i = 0; i < acr_pkg::NREG; i++) begin : g_reg
    assign hit[i] = (hdr_q[acr_pkg::AW-1:0] == acr_pkg::REG_ADDR[i]);
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        reg_q[i] <= acr_pkg::REG_RST[i];
      end else if (wr_stb_q && hit[i]) begin
        reg_q[i] <= wr_data_q & acr_pkg::REG_MASK[i];
      end
    end
  end

  // Decoded settings
  logic ind_on;
  logic [3:0] word_rate;
  logic [3:0] clk_code;
  logic [3:0] clk_eff;
  logic clk_none;
  logic dl_on;
  logic dl_block;
  logic data_run;
  logic clk_run;
  logic [9:0] ref_div;
  logic data_tick;
  logic clk_tick;
  logic [3:0] data_pow;
  logic [3:0] clk_pow;
  logic [11:0] sample_q;
  logic wck_raw_q;
  logic wck_raw_d;

  assign ind_on = reg_q[acr_pkg::IDX_CHAN][acr_pkg::POS_IND_DIV];
  assign word_rate = reg_q[acr_pkg::IDX_RATE][acr_pkg::POS_WRATE +: 4];
  assign clk_code = reg_q[acr_pkg::IDX_RATE][acr_pkg::POS_CRATE +: 4];
  assign dl_on = reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DL_ON];
  assign ref_div = {reg_q[acr_pkg::IDX_OUTREF][acr_pkg::POS_REFHI +: 2],
    reg_q[acr_pkg::IDX_REFLO]};

  // Clock follows the word rate unless the independent divider is on
  always_comb begin
    if (ind_on) begin
      clk_eff = clk_code;
    end else if (word_rate != 4'h0 && word_rate <= acr_pkg::RATE_MAX_DIV) begin
      clk_eff = word_rate;
    end else begin
      clk_eff = acr_pkg::CRATE_FULL;
    end
  end

  assign clk_none = (clk_eff == acr_pkg::CRATE_NONE) ||
    (clk_eff > acr_pkg::RATE_MAX_DIV && clk_eff != acr_pkg::CRATE_FULL);
  assign dl_block = dl_on && (!reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DL_CLK] ||
    !reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DL_RUN]);
  assign data_run = reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_CLKBUF] && !dl_block;
  assign clk_run = data_run && !clk_none;
  // Reserved word rate codes are left to the host to avoid; they pass full rate
  assign data_pow = (word_rate <= acr_pkg::RATE_MAX_DIV) ? word_rate : 4'h0;
  assign clk_pow = (clk_eff <= acr_pkg::RATE_MAX_DIV) ? clk_eff : 4'h0;
  assign wck_raw_d = data_tick ? !wck_raw_q : wck_raw_q;

  acr_rate_div u_data_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(adc_valid_i && data_run),
    .pow_i(data_pow),
    .tick_o(data_tick)
  );

  acr_rate_div u_clk_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(adc_valid_i && clk_run),
    .pow_i(clk_pow),
    .tick_o(clk_tick)
  );

  // Output data path
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sample_q <= 12'h000;
      out_valid_o <= 1'b0;
      out_data_o <= 12'h000;
    end else begin
      if (adc_valid_i) begin
        sample_q <= adc_data_i;
      end
      out_valid_o <= data_tick && data_run;
      if (data_tick) begin
        if (word_rate >= acr_pkg::WRATE_ZERO_MIN) begin
          out_data_o <= 12'h000;
        end else if (reg_q[acr_pkg::IDX_SCRAMBLE][acr_pkg::POS_RAND]) begin
          out_data_o <= {sample_q[11:1] ^ {11{sample_q[0]}}, sample_q[0]};
        end else begin
          out_data_o <= sample_q;
        end
      end
    end
  end

  // Word clock toggles once per output word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wck_raw_q <= 1'b0;
      word_clock_pin_o <= 1'b0;
    end else begin
      wck_raw_q <= wck_raw_d;
      word_clock_pin_o <= wck_raw_d ^ reg_q[acr_pkg::IDX_SCRAMBLE][acr_pkg::POS_WCK_INV];
    end
  end

  // Differential output clock, both legs low while stopped
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      output_clock_pins_p_o <= 1'b0;
      output_clock_pins_n_o <= 1'b0;
    end else if (!clk_run) begin
      output_clock_pins_p_o <= 1'b0;
      output_clock_pins_n_o <= 1'b0;
    end else if (clk_tick) begin
      output_clock_pins_p_o <= !output_clock_pins_p_o;
      output_clock_pins_n_o <= output_clock_pins_p_o;
    end else begin
      output_clock_pins_n_o <= !output_clock_pins_p_o;
    end
  end

  // Delay loop, timing source and synthesizer dividers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_clock_phase_o <= 3'h0;
      duty_correct_on_o <= 1'b0;
      delay_loop_on_o <= 1'b0;
      delay_loop_reset_o <= 1'b1;
      clock_buffer_on_o <= 1'b1;
      timing_source_synth_o <= 1'b0;
      synth_ref_ratio_o <= 10'h001;
      synth_out_ratio_o <= 4'h4;
    end else begin
      out_clock_phase_o <= (dl_on && phase_delay_on_i && word_rate == 4'h0) ?
        reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_PHASE +: 3] : 3'h0;
      duty_correct_on_o <= reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DUTY];
      delay_loop_on_o <= dl_on;
      delay_loop_reset_o <= !reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DL_RUN];
      clock_buffer_on_o <= reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_CLKBUF];
      timing_source_synth_o <= reg_q[acr_pkg::IDX_TSRC][acr_pkg::POS_TSRC];
      if (!reg_q[acr_pkg::IDX_SYNTH_EN][acr_pkg::POS_REF_ON] || ref_div < acr_pkg::REFDIV_MIN) begin
        synth_ref_ratio_o <= 10'h001;
      end else begin
        synth_ref_ratio_o <= ref_div;
      end
      synth_out_ratio_o <= (reg_q[acr_pkg::IDX_OUTREF][acr_pkg::POS_OUTDIV +: 4] == 4'h0) ?
        4'h1 : reg_q[acr_pkg::IDX_OUTREF][acr_pkg::POS_OUTDIV +: 4];
    end
  end

  acr_cal_timer #(
    .STEP_CYC(CAL_STEP_CYC)
  ) u_cal (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(calib_request_i),
    .delay_on_i(reg_q[acr_pkg::IDX_SCRAMBLE][acr_pkg::POS_CAL_ON]),
    .delay_val_i(reg_q[acr_pkg::IDX_CALDLY]),
    .busy_o(calib_busy_o),
    .fire_o(calib_start_o)
  );

  // Checks
  zero_data_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_tick && word_rate >= acr_pkg::WRATE_ZERO_MIN) |=> out_data_o == 12'h000)
    else $error("data not zero for zero-output word rate");
  full_rate_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (adc_valid_i && data_run && word_rate == 4'h0) [*3] |-> ##1 out_valid_o)
    else $error("full word rate dropped a word");
  clock_quiet_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_none |=> (!output_clock_pins_p_o && !output_clock_pins_n_o))
    else $error("clock pins active with no-clock code");
  buffer_off_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_CLKBUF] [*3] |-> !out_valid_o)
    else $error("output words with clock buffer off");
  loop_reset_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(reg_q[acr_pkg::IDX_DLOOP][acr_pkg::POS_DL_RUN]) |=> delay_loop_reset_o)
    else $error("delay loop not held in reset");
  ref_ratio_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_q[acr_pkg::IDX_SYNTH_EN][acr_pkg::POS_REF_ON] && ref_div >= acr_pkg::REFDIV_MIN)
    |=> synth_ref_ratio_o == $past(ref_div))
    else $error("reference ratio wrong");
  out_ratio_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (reg_q[acr_pkg::IDX_OUTREF][acr_pkg::POS_OUTDIV +: 4] == 4'h0) |=> synth_out_ratio_o == 4'h1)
    else $error("undivided output ratio wrong");
  word_clock_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    out_valid_o |-> word_clock_pin_o == (wck_raw_q ^
    $past(reg_q[acr_pkg::IDX_SCRAMBLE][acr_pkg::POS_WCK_INV])))
    else $error("word clock polarity wrong");
  decimate_c : cover property (@(posedge ref_clk_i) disable iff (rst_i)
    out_valid_o && word_rate == 4'h3);
  indep_clock_c : cover property (@(posedge ref_clk_i) disable iff (rst_i) ind_on && clk_tick);
  reg_write_c : cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wr_stb_q && hit[acr_pkg::IDX_DLOOP]);
endmodule : acr_top

// ---- design/acr_pkg.sv ----
// Package with register map, field positions, codes and timing constants
package acr_pkg;
  // Register file: index, serial address and value after reset
  localparam int NREG = 10;
  localparam int AW = 13;
  localparam int IDX_CHAN = 0;
  localparam int IDX_RATE = 1;
  localparam int IDX_SERIAL = 2;
  localparam int IDX_SCRAMBLE = 3;
  localparam int IDX_CALDLY = 4;
  localparam int IDX_DLOOP = 5;
  localparam int IDX_TSRC = 6;
  localparam int IDX_REFLO = 7;
  localparam int IDX_OUTREF = 8;
  localparam int IDX_SYNTH_EN = 9;
  localparam logic [AW-1:0] REG_ADDR [NREG] = '{13'h0001, 13'h0002, 13'h0004, 13'h0007,
    13'h001E, 13'h0052, 13'h0053, 13'h0054, 13'h0055, 13'h0059};
  localparam logic [7:0] REG_RST [NREG] = '{8'h0F, 8'h00, 8'h9F, 8'h62, 8'h80, 8'h0A,
    8'h45, 8'h00, 8'h48, 8'h41};
  localparam logic [7:0] REG_MASK [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'h7F};
  // Field positions
  localparam int POS_IND_DIV = 7;
  localparam int POS_WRATE = 4;
  localparam int POS_CRATE = 0;
  localparam int POS_EDGE = 7;
  localparam int POS_WCK_INV = 7;
  localparam int POS_CAL_ON = 6;
  localparam int POS_RAND = 0;
  localparam int POS_DUTY = 7;
  localparam int POS_PHASE = 4;
  localparam int POS_DL_CLK = 3;
  localparam int POS_DL_ON = 2;
  localparam int POS_CLKBUF = 1;
  localparam int POS_DL_RUN = 0;
  localparam int POS_TSRC = 4;
  localparam int POS_OUTDIV = 4;
  localparam int POS_REFHI = 0;
  localparam int POS_REF_ON = 4;
  // Rate codes
  localparam logic [3:0] RATE_MAX_DIV = 4'h9;
  localparam logic [3:0] WRATE_ZERO_MIN = 4'hD;
  localparam logic [3:0] CRATE_FULL = 4'hF;
  localparam logic [3:0] CRATE_NONE = 4'h0;
  localparam logic [9:0] REFDIV_MIN = 10'h003;
  // Serial frame: read flag, address, then one data byte
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int POS_RD = 15;
  // Calibration start delay: one step per count of the delay setting, plus one step
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_STEP_NS = 1000;
  localparam int CAL_STEP_CYC = (CAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : acr_pkg

// ---- design/acr_rate_div.sv ----
// Power-of-two tick divider
`timescale 1ns/1ns
module acr_rate_div (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic [3:0] pow_i,
  output logic tick_o
);
  logic [9:0] cnt_q;
  logic [9:0] lim;

  assign lim = 10'((10'h001 << pow_i) - 10'h001);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= 10'h000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (cnt_q >= lim) begin
          cnt_q <= 10'h000;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= 10'(cnt_q + 10'h001);
        end
      end
    end
  end
endmodule : acr_rate_div

// ---- design/acr_cal_timer.sv ----
// Calibration start delay timer
`timescale 1ns/1ns
module acr_cal_timer #(
  parameter int STEP_CYC = acr_pkg::CAL_STEP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic delay_on_i,
  input wire logic [7:0] delay_val_i,
  output logic busy_o,
  output logic fire_o
);
  logic [19:0] cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= 20'h00000;
      busy_o <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (!busy_o && start_i) begin
        if (delay_on_i) begin
          cnt_q <= 20'((20'(delay_val_i) + 20'h00001) * 20'(STEP_CYC));
          busy_o <= 1'b1;
        end else begin
          fire_o <= 1'b1;
        end
      end else if (busy_o) begin
        if (cnt_q <= 20'h00001) begin
          busy_o <= 1'b0;
          fire_o <= 1'b1;
        end else begin
          cnt_q <= 20'(cnt_q - 20'h00001);
        end
      end
    end
  end

  undelayed_start_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_o && start_i && !delay_on_i) |=> fire_o)
    else $error("calibration did not start at once with delay off");
  delay_hold_a : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!busy_o && start_i && delay_on_i) |=> (busy_o && !fire_o))
    else $error("calibration started before its delay");
  cal_delay_c : cover property (@(posedge ref_clk_i) disable iff (rst_i)
    busy_o ##1 fire_o);
endmodule : acr_cal_timer

// ---- verification/acr_host_model.sv ----
// Serial host model for the configuration port
`timescale 1ns/1ns
module acr_host_model (
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
  end
  // One frame: read flag, address, data byte; sclk half period is three cycles
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
      output logic [7:0] q, output logic e);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    q = 8'h00;
    e = 1'b0;
    if (!rd && a == 13'h0002 && wd[7:4] inside {[4'hA:4'hC]}) f[7:4] = 4'h0;
    cs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_o <= f[i];
      repeat (3) @(posedge ref_clk_i);
      if (i < 8) q[i] = sdo_i;
      sclk_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      if (i == 8) e = sdo_i;
      sclk_o <= 1'b0;
    end
    repeat (3) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~f[0];
    repeat (4) @(posedge ref_clk_i);
  endtask : xfer
endmodule : acr_host_model

// ---- verification/tb_adc_clock_output_rate_config.sv ----
// Self-checking bench for the clock and output rate configuration block
`timescale 1ns/1ns
module tb_adc_clock_output_rate_config;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, spi_sclk_i, spi_cs_n_i, spi_sdi_i, adc_valid_i = 1'b0;
  logic phase_delay_on_i = 1'b0, calib_request_i = 1'b0, p_q = 1'b0, w_q = 1'b0, eb;
  logic [11:0] adc_data_i = 12'h000, out_data_o;
  logic spi_sdo_o, spi_sdo_oe_n_o, out_valid_o, word_clock_pin_o, output_clock_pins_p_o;
  logic output_clock_pins_n_o, duty_correct_on_o, delay_loop_on_o, delay_loop_reset_o;
  logic clock_buffer_on_o, timing_source_synth_o, calib_busy_o, calib_start_o;
  logic [2:0] out_clock_phase_o;
  logic [9:0] synth_ref_ratio_o;
  logic [3:0] synth_out_ratio_o;
  logic [7:0] rv;
  int err_total = 0, checks = 0, n_v = 0, n_p = 0, n_w = 0, n_o = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  acr_top #(.CAL_STEP_CYC(1)) dut (.ref_clk_i, .rst_i, .spi_sclk_i, .spi_cs_n_i, .spi_sdi_i,
    .spi_sdo_o, .spi_sdo_oe_n_o, .adc_valid_i, .adc_data_i, .phase_delay_on_i,
    .calib_request_i, .out_valid_o, .out_data_o, .word_clock_pin_o, .output_clock_pins_p_o,
    .output_clock_pins_n_o, .out_clock_phase_o, .duty_correct_on_o, .delay_loop_on_o,
    .delay_loop_reset_o, .clock_buffer_on_o, .timing_source_synth_o, .synth_ref_ratio_o,
    .synth_out_ratio_o, .calib_busy_o, .calib_start_o);
  acr_host_model host (.ref_clk_i, .sdo_i(spi_sdo_o), .sclk_o(spi_sclk_i),
    .cs_n_o(spi_cs_n_i), .sdi_o(spi_sdi_i));
  // Counts output words, clock pin and word clock toggles
  always @(posedge ref_clk_i) begin
    p_q <= output_clock_pins_p_o;
    w_q <= word_clock_pin_o;
    if (out_valid_o === 1'b1) n_v++;
    if (output_clock_pins_p_o !== p_q) n_p++;
    if (word_clock_pin_o !== w_q) n_w++;
    if (spi_sdo_oe_n_o === 1'b0) n_o++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rv, eb);
  endtask : wr
  task automatic rd(input logic [12:0] a);
    host.xfer(1'b1, a, 8'h00, rv, eb);
  endtask : rd
  task automatic feed(input int n);
    n_v = 0;
    n_p = 0;
    n_w = 0;
    repeat (n) begin
      @(posedge ref_clk_i);
      adc_valid_i <= 1'b1;
    end
    @(posedge ref_clk_i);
    adc_valid_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask : feed
  task automatic samp(input logic [11:0] d, input logic [11:0] e);
    int t;
    @(posedge ref_clk_i);
    adc_valid_i <= 1'b1;
    adc_data_i <= d;
    @(posedge ref_clk_i);
    adc_valid_i <= 1'b0;
    t = 0;
    while (out_valid_o !== 1'b1 && t < 6) begin
      @(posedge ref_clk_i);
      t++;
    end
    chk({t < 6, out_data_o}, {1'b1, e});
  endtask : samp
  task automatic t_regs();
    chk({delay_loop_reset_o, clock_buffer_on_o, delay_loop_on_o}, 3'b110);
    chk({synth_ref_ratio_o, synth_out_ratio_o}, {10'h001, 4'h4});
    for (int k = 0; k < acr_pkg::NREG; k++) begin
      rd(acr_pkg::REG_ADDR[k]);
      chk(rv, acr_pkg::REG_RST[k] & acr_pkg::REG_MASK[k]);
    end
    wr(13'h0003, 8'h5A);
    rd(13'h0003);
    chk(rv, 8'h00);
    wr(13'h0059, 8'hC1);
    rd(13'h0059);
    chk(rv, 8'h41);
  endtask : t_regs
  task automatic t_words();
    logic l;
    samp(12'h5A3, 12'h5A3);
    wr(13'h0007, 8'h63);
    samp(12'h5A3, 12'hA5D);
    l = word_clock_pin_o;
    wr(13'h0007, 8'hE2);
    chk(word_clock_pin_o, !l);
    wr(13'h0007, 8'h62);
    for (int c = 13; c < 16; c++) begin
      wr(13'h0002, {c[3:0], 4'h0});
      samp(12'hFFF, 12'h000);
    end
    for (int c = 0; c < 10; c++) begin
      wr(13'h0002, {c[3:0], 4'h0});
      feed(1024);
      chk({n_v, n_w}, {32'(1024 >> c), 32'(1024 >> c)});
    end
  endtask : t_words
  task automatic t_clock();
    logic [3:0] cd [6] = '{4'hF, 4'h0, 4'h2, 4'h9, 4'hA, 4'hE};
    int ex [6] = '{1024, 0, 256, 2, 0, 0};
    wr(13'h0001, 8'h8F);
    for (int k = 0; k < 6; k++) begin
      wr(13'h0002, {4'h0, cd[k]});
      feed(1024);
      chk(n_p, ex[k]);
      if (ex[k] == 0) chk({output_clock_pins_p_o, output_clock_pins_n_o}, 2'b00);
      else chk({output_clock_pins_p_o, output_clock_pins_n_o}, 2'b01);
    end
    wr(13'h0001, 8'h0F);
    feed(64);
    chk(n_p, 64);
    wr(13'h0002, 8'h00);
  endtask : t_clock
  task automatic t_loop();
    phase_delay_on_i <= 1'b1;
    wr(13'h0052, 8'hB6);
    chk({duty_correct_on_o, out_clock_phase_o, delay_loop_on_o}, 5'b10111);
    chk(delay_loop_reset_o, 1'b1);
    feed(8);
    chk(n_v, 0);
    wr(13'h0052, 8'hBF);
    chk({delay_loop_reset_o, clock_buffer_on_o}, 2'b01);
    feed(8);
    chk(n_v, 8);
    phase_delay_on_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(out_clock_phase_o, 3'h0);
    wr(13'h0052, 8'h08);
    chk({duty_correct_on_o, delay_loop_on_o, clock_buffer_on_o}, 3'b000);
    feed(8);
    chk(n_v, 0);
    wr(13'h0052, 8'h0A);
  endtask : t_loop
  task automatic t_synth();
    wr(13'h0053, 8'h55);
    chk(timing_source_synth_o, 1'b1);
    wr(13'h0054, 8'h05);
    chk(synth_ref_ratio_o, 10'h001);
    wr(13'h0059, 8'h51);
    chk(synth_ref_ratio_o, 10'h005);
    wr(13'h0055, 8'h09);
    chk({synth_ref_ratio_o, synth_out_ratio_o}, {10'h105, 4'h1});
    wr(13'h0054, 8'h03);
    wr(13'h0055, 8'hF8);
    chk({synth_ref_ratio_o, synth_out_ratio_o}, {10'h003, 4'hF});
  endtask : t_synth
  task automatic cal(output int lat, output logic bz);
    @(posedge ref_clk_i);
    calib_request_i <= 1'b1;
    @(posedge ref_clk_i);
    calib_request_i <= 1'b0;
    lat = 0;
    bz = 1'b0;
    while (calib_start_o !== 1'b1 && lat < 600) begin
      @(posedge ref_clk_i);
      lat++;
      if (lat == 1) bz = calib_busy_o;
    end
  endtask : cal
  task automatic t_cal();
    int a, b, c, d;
    logic za, zx, zd;
    cal(a, za);
    wr(13'h001E, 8'h00);
    cal(b, zx);
    wr(13'h001E, 8'h04);
    cal(c, zx);
    wr(13'h0007, 8'h22);
    cal(d, zd);
    chk({za, zd}, 2'b10);
    chk(a - b, 128);
    chk(c - b, 4);
    chk(d < b, 1);
    wr(13'h0007, 8'h62);
  endtask : t_cal
  task automatic t_edge();
    n_o = 0;
    wr(13'h0004, 8'h1F);
    chk(n_o, 0);
    rd(13'h0055);
    chk({rv, eb, n_o > 0, spi_sdo_oe_n_o}, {8'hF8, 1'b1, 1'b1, 1'b1});
    wr(13'h0004, 8'h9F);
    rd(13'h0055);
    chk(rv, 8'hF8);
  endtask : t_edge
  task automatic close_out();
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    #2500000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_regs();
    t_words();
    t_clock();
    t_loop();
    t_synth();
    t_cal();
    t_edge();
    close_out();
  end
endmodule : tb_adc_clock_output_rate_config
